// >>> src/pvc_cfg.svh
// Register offsets, field positions, reset values and counts for the
// PLL VCO calibration and counter sync control block.
// Assumes a 10-bit byte-wide register port.
`ifndef PVC_CFG_SVH
`define PVC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PVC_ADDR_CAL_CTRL 10'h018
`define PVC_ADDR_SYNC_DLY 10'h019
`define PVC_ADDR_CAL_STAT 10'h01f
`define PVC_ADDR_UPDATE 10'h232

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PVC_CAL_START_BIT 0
`define PVC_CAL_DIV_MSB 2
`define PVC_CAL_DIV_LSB 1
`define PVC_SYNC_MODE_MSB 7
`define PVC_SYNC_MODE_LSB 6
`define PVC_REF_DLY_MSB 5
`define PVC_REF_DLY_LSB 3
`define PVC_FB_DLY_MSB 2
`define PVC_FB_DLY_LSB 0
`define PVC_UPDATE_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PVC_CAL_CTRL_RST 8'h06
`define PVC_SYNC_DLY_RST 8'h00

// ----------------------------------------------------------------------
// Divider half periods minus one, in reference edges
// ----------------------------------------------------------------------
`define PVC_HALF_DIV2 4'h0
`define PVC_HALF_DIV4 4'h1
`define PVC_HALF_DIV8 4'h3
`define PVC_HALF_DIV16 4'h7

// ----------------------------------------------------------------------
// Calibration length in calibration clock periods
// ----------------------------------------------------------------------
`define PVC_CAL_PERIODS 8'h80

`endif

// >>> src/pvc_pkg.sv
// Types for the PLL VCO calibration and counter sync control block.
// Assumes pvc_cfg.svh holds the numeric constants.
package pvc_pkg;

    typedef enum logic [1:0]
    {
        PVC_IDLE = 2'b00,
        PVC_RUN = 2'b01,
        PVC_DONE = 2'b11
    } pvc_state_e;

    typedef enum logic [1:0]
    {
        PVC_SYNC_IGN_LO = 2'b00,
        PVC_SYNC_ASYNC = 2'b01,
        PVC_SYNC_SYNC = 2'b10,
        PVC_SYNC_IGN_HI = 2'b11
    } pvc_sync_e;

    typedef struct packed
    {
        logic ref_s1;
        logic ref_s2;
        logic ref_s3;
        logic syn_s1;
        logic syn_s2;
        logic [7:0] buf_cal;
        logic [7:0] buf_sd;
        logic [7:0] act_cal;
        logic [7:0] act_sd;
        pvc_state_e st;
        logic [3:0] div_cnt;
        logic cal_clk;
        logic [7:0] per_cnt;
        logic valid;
        logic busy;
        logic ctr_rst;
        logic [7:0] rdata;
    } pvc_state_s;

endpackage

// >>> src/pvc_top.sv
// PLL VCO calibration control, calibration clock divider, counter sync
// mode and path delay settings, with staged and active register sets.
// Assumes a single 250 MHz clock; ref_clk and sync_pin_n are pins.
`timescale 1ns/1ps
`default_nettype none
`include "pvc_cfg.svh"

// How it works
// - Divider code 10b divides the reference by 8 for the calibration clock.
// - Divider code resets to 11b, dividing by 16, slowest calibration.
// - Calibration starts only when the active start bit goes 0 to 1.
// - Clearing the active start bit discards the calibration result.
// - Sync mode 00b/11b ignore sync, 01b async reset, 10b sync reset.
// - Fields [5:3] and [2:0] pick reference and feedback path delay.
// - Divider codes 00b and 01b divide the reference by 2 and 4.
module pvc_top
    import pvc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic ref_clk,
    input wire logic sync_pin_n,
    output logic cal_clk,
    output logic cal_busy,
    output logic cal_valid,
    output logic ctr_rst,
    output logic [2:0] ref_delay,
    output logic [2:0] fb_delay
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [9:0] a, input logic [9:0] o);
        hit = (a == o);
    endfunction

    function automatic logic [3:0] half_of(input logic [1:0] code);
        logic [3:0] h;
        h = `PVC_HALF_DIV16;
        unique case (code)
            2'b00: h = `PVC_HALF_DIV2;
            2'b01: h = `PVC_HALF_DIV4;
            2'b10: h = `PVC_HALF_DIV8;
            2'b11: h = `PVC_HALF_DIV16;
        endcase
        half_of = h;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pvc_state_s s_r;
    pvc_state_s s_nxt;

    logic ref_rise;
    logic upd;
    logic start_rise;
    logic start_fall;
    logic [1:0] div_code;
    logic [3:0] half;
    logic cal_rise;
    pvc_sync_e mode;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ref_s1 = ref_clk;
        s_nxt.ref_s2 = s_r.ref_s1;
        s_nxt.ref_s3 = s_r.ref_s2;
        s_nxt.syn_s1 = sync_pin_n;
        s_nxt.syn_s2 = s_r.syn_s1;
        ref_rise = s_r.ref_s2 & ~s_r.ref_s3;

        // Register writes land in the staged set
        if (wr && hit(addr, `PVC_ADDR_CAL_CTRL))
        begin
            s_nxt.buf_cal = wdata;
        end
        if (wr && hit(addr, `PVC_ADDR_SYNC_DLY))
        begin
            s_nxt.buf_sd = wdata;
        end

        // Update copies staged set into active set
        upd = wr && hit(addr, `PVC_ADDR_UPDATE)
            && wdata[`PVC_UPDATE_BIT];
        start_rise = upd && s_r.buf_cal[`PVC_CAL_START_BIT]
            && !s_r.act_cal[`PVC_CAL_START_BIT];
        start_fall = upd && !s_r.buf_cal[`PVC_CAL_START_BIT]
            && s_r.act_cal[`PVC_CAL_START_BIT];
        if (upd)
        begin
            s_nxt.act_cal = s_r.buf_cal;
            s_nxt.act_sd = s_r.buf_sd;
        end

        // Calibration clock divider on reference edges
        div_code = s_r.act_cal[`PVC_CAL_DIV_MSB:`PVC_CAL_DIV_LSB];
        half = half_of(div_code);
        cal_rise = 1'b0;
        if (ref_rise)
        begin
            if (s_r.div_cnt >= half)
            begin
                s_nxt.div_cnt = 4'h0;
                s_nxt.cal_clk = ~s_r.cal_clk;
                cal_rise = ~s_r.cal_clk;
            end
            else
            begin
                s_nxt.div_cnt = s_r.div_cnt + 4'h1;
            end
        end

        // Calibration sequence
        unique case (s_r.st)
            PVC_IDLE:
            begin
                if (start_rise)
                begin
                    s_nxt.st = PVC_RUN;
                    s_nxt.per_cnt = 8'h00;
                    s_nxt.valid = 1'b0;
                end
            end
            PVC_RUN:
            begin
                if (cal_rise)
                begin
                    s_nxt.per_cnt = s_r.per_cnt + 8'h01;
                    if (s_r.per_cnt == `PVC_CAL_PERIODS - 8'h01)
                    begin
                        s_nxt.st = PVC_DONE;
                        s_nxt.valid = 1'b1;
                    end
                end
            end
            PVC_DONE:
            begin
                s_nxt.st = PVC_DONE;
            end
            default:
            begin
                s_nxt.st = PVC_IDLE;
            end
        endcase
        if (start_fall)
        begin
            s_nxt.st = PVC_IDLE;
            s_nxt.valid = 1'b0;
            s_nxt.per_cnt = 8'h00;
        end
        s_nxt.busy = (s_nxt.st == PVC_RUN);

        // Counter reset from the sync pin
        mode = pvc_sync_e'(s_r.act_sd[`PVC_SYNC_MODE_MSB:`PVC_SYNC_MODE_LSB]);
        unique case (mode)
            PVC_SYNC_ASYNC:
            begin
                s_nxt.ctr_rst = ~s_r.syn_s2;
            end
            PVC_SYNC_SYNC:
            begin
                if (ref_rise)
                begin
                    s_nxt.ctr_rst = ~s_r.syn_s2;
                end
            end
            PVC_SYNC_IGN_LO, PVC_SYNC_IGN_HI:
            begin
                s_nxt.ctr_rst = 1'b0;
            end
        endcase

        // Read port
        s_nxt.rdata = 8'h00;
        if (rd)
        begin
            if (hit(addr, `PVC_ADDR_CAL_CTRL))
            begin
                s_nxt.rdata = s_r.buf_cal;
            end
            else if (hit(addr, `PVC_ADDR_SYNC_DLY))
            begin
                s_nxt.rdata = s_r.buf_sd;
            end
            else if (hit(addr, `PVC_ADDR_CAL_STAT))
            begin
                s_nxt.rdata = {4'h0, s_r.act_cal[`PVC_CAL_START_BIT],
                    s_r.cal_clk, s_r.valid, (s_r.st == PVC_RUN)};
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_r <= '0;
            s_r.buf_cal <= `PVC_CAL_CTRL_RST;
            s_r.act_cal <= `PVC_CAL_CTRL_RST;
            s_r.buf_sd <= `PVC_SYNC_DLY_RST;
            s_r.act_sd <= `PVC_SYNC_DLY_RST;
            s_r.st <= PVC_IDLE;
            s_r.syn_s1 <= 1'b1;
            s_r.syn_s2 <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata = s_r.rdata;
    assign cal_clk = s_r.cal_clk;
    assign cal_busy = s_r.busy;
    assign cal_valid = s_r.valid;
    assign ctr_rst = s_r.ctr_rst;
    assign ref_delay = s_r.act_sd[`PVC_REF_DLY_MSB:`PVC_REF_DLY_LSB];
    assign fb_delay = s_r.act_sd[`PVC_FB_DLY_MSB:`PVC_FB_DLY_LSB];

endmodule

`default_nettype wire

// >>> tb/pvc_top_assertions.sv
// Port checker for pvc_top.
// Assumes it is bound to pvc_top.
`timescale 1ns/1ps
`default_nettype none
`include "pvc_cfg.svh"
module pvc_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic cal_busy,
    input wire logic cal_valid,
    input wire logic ctr_rst,
    input wire logic [2:0] ref_delay,
    input wire logic [2:0] fb_delay
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire upd = wr && addr == `PVC_ADDR_UPDATE && wdata[0];
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("rdata not zero outside read");
    AST_STAT: assert property (rd && addr == `PVC_ADDR_CAL_STAT
        |=> rdata[1:0] == $past({cal_valid, cal_busy}))
        else $error("status read mismatch");
    AST_UPD_RD: assert property (rd && addr == `PVC_ADDR_UPDATE
        |=> rdata == 8'h00) else $error("update read not zero");
    AST_EXCL: assert property (!(cal_busy && cal_valid))
        else $error("busy and valid together");
    AST_START: assert property ($rose(cal_busy) |-> $past(upd))
        else $error("calibration started without update");
    AST_DONE: assert property ($rose(cal_valid) |-> $fell(cal_busy))
        else $error("valid without busy ending");
    AST_DROP: assert property ($fell(cal_valid) |-> $past(upd))
        else $error("valid dropped without update");
    AST_ABORT: assert property ($fell(cal_busy)
        |-> cal_valid || $past(upd) || $past(upd, 2))
        else $error("busy dropped unexpectedly");
    AST_RDLY: assert property ((ref_delay != $past(ref_delay))
        |-> $past(upd)) else $error("ref delay moved alone");
    AST_FDLY: assert property ((fb_delay != $past(fb_delay))
        |-> $past(upd)) else $error("fb delay moved alone");
    cover property ($rose(cal_busy));
    cover property ($rose(cal_valid));
    cover property ($rose(ctr_rst));
endmodule
bind pvc_top pvc_checker u_chk (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cal_busy(cal_busy),
    .cal_valid(cal_valid), .ctr_rst(ctr_rst), .ref_delay(ref_delay),
    .fb_delay(fb_delay));
`default_nettype wire

// >>> tb/test_pll_vco_calibration_control_and_counter_sync.sv
// Self-checking bench for pvc_top.
// Assumes pvc_pkg and pvc_cfg.svh.
`timescale 1ns/1ps
`default_nettype none
`include "pvc_cfg.svh"
`define CHK(n, e, a) begin samples_checked++; \
    if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_pll_vco_calibration_control_and_counter_sync;
    logic clk, nrst, wr, rd, sync_pin_n;
    logic cal_clk, cal_busy, cal_valid, ctr_rst;
    logic [9:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [2:0] ref_delay, fb_delay;
    logic [1:0] rdiv = 2'h0;
    int err_count, samples_checked, n, p;
    pvc_top uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ref_clk(rdiv[1]),
        .sync_pin_n(sync_pin_n), .cal_clk(cal_clk), .cal_busy(cal_busy),
        .cal_valid(cal_valid), .ctr_rst(ctr_rst), .ref_delay(ref_delay),
        .fb_delay(fb_delay));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) rdiv <= rdiv + 2'h1;
    task close_out;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task wreg(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [9:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task upd;
        wreg(`PVC_ADDR_UPDATE, 8'h01);
    endtask
    task waitv(input logic s, input logic v);
        n = 0;
        #1;
        while (((s ? cal_valid : cal_clk) !== v) && n < 3000)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 3000)
        begin
            err_count++;
            close_out;
        end
    endtask
    initial
    begin
        nrst = 1'b0;
        {wr, rd, addr, wdata} = '0;
        sync_pin_n = 1'b1;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rreg(`PVC_ADDR_CAL_CTRL);
        `CHK("cal_ctrl", 8'h06, d)
        rreg(`PVC_ADDR_SYNC_DLY);
        `CHK("sync_dly", 8'h00, d)
        rreg(10'h3ff);
        `CHK("unmapped", 8'h00, d)
        rreg(`PVC_ADDR_UPDATE);
        `CHK("update_rd", 8'h00, d)
        wreg(`PVC_ADDR_SYNC_DLY, 8'h1a);
        rreg(`PVC_ADDR_SYNC_DLY);
        `CHK("staged", 8'h1a, d)
        `CHK("ref_early", 3'h0, ref_delay)
        upd;
        @(posedge clk);
        #1 `CHK("ref_delay", 3'h3, ref_delay)
        `CHK("fb_delay", 3'h2, fb_delay)
        $display("test registers done");
        for (int m = 0; m < 4; m++)
        begin
            wreg(`PVC_ADDR_SYNC_DLY, {m[1:0], 6'h00});
            upd;
            sync_pin_n <= 1'b0;
            repeat (12) @(posedge clk);
            #1 `CHK("ctr_rst_on", (m == 1 || m == 2), ctr_rst)
            @(posedge clk) sync_pin_n <= 1'b1;
            repeat (12) @(posedge clk);
            #1 `CHK("ctr_rst_off", 1'b0, ctr_rst)
        end
        $display("test sync done");
        for (int c = 0; c < 4; c++)
        begin
            wreg(`PVC_ADDR_CAL_CTRL, {5'h00, c[1:0], 1'b0});
            upd;
            waitv(0, 0);
            waitv(0, 1);
            waitv(0, 0);
            p = n;
            waitv(0, 1);
            p += n;
            `CHK("cal_clk_period", 8 << c, p)
        end
        $display("test divider done");
        wreg(`PVC_ADDR_CAL_CTRL, 8'h00);
        upd;
        wreg(`PVC_ADDR_CAL_CTRL, 8'h01);
        upd;
        @(posedge clk);
        #1 `CHK("busy", 1'b1, cal_busy)
        waitv(1, 1);
        `CHK("busy_end", 1'b0, cal_busy)
        rreg(`PVC_ADDR_CAL_STAT);
        `CHK("status", 8'h0a, d & 8'hfb)
        upd;
        @(posedge clk);
        #1 `CHK("no_restart", 1'b0, cal_busy)
        `CHK("still_valid", 1'b1, cal_valid)
        wreg(`PVC_ADDR_CAL_CTRL, 8'h00);
        upd;
        @(posedge clk);
        #1 `CHK("discard", 1'b0, cal_valid)
        wreg(`PVC_ADDR_CAL_CTRL, 8'h01);
        upd;
        repeat (20) @(posedge clk);
        wreg(`PVC_ADDR_CAL_CTRL, 8'h00);
        upd;
        repeat (2) @(posedge clk);
        #1 `CHK("abort", 2'b00, {cal_busy, cal_valid})
        $display("test calibration done");
        close_out;
    end
endmodule
`default_nettype wire
